// ---- design/elf_regs.vh ----
/*
 * Register offsets, field positions, reset values and timing counts of the
 * event logger control block. Assumes a 10 MHz logger clock.
 */
`ifndef ELF_REGS_VH
`define ELF_REGS_VH

`define ELF_ADDR_W 24
`define ELF_OFF_CONTROL 24'h110000
`define ELF_OFF_TIMER_SRC 24'h110008
`define ELF_OFF_THRESHOLD 24'h110018
`define ELF_OFF_PTR_STATUS 24'h11001C

`define ELF_CTL_EN_BIT 0
`define ELF_CTL_CLR_BIT 1
`define ELF_CTL_CLKREQ_BIT 8
`define ELF_CTL_DB_LSB 16
`define ELF_CTL_DB_MSB 19
`define ELF_PS_RIDX_LSB 0
`define ELF_PS_RIDX_MSB 3
`define ELF_PS_WIDX_LSB 8
`define ELF_PS_WIDX_MSB 11
`define ELF_PS_PENDING_BIT 16
`define ELF_PS_THRESH_BIT 17
`define ELF_PS_FULL_BIT 18

`define ELF_RST_THRESHOLD 4'h1
`define ELF_DB_MAX_CODE 4'hA

// base debounce 93.75 us at 10 MHz: 937.5 cycles, rounded up
`define ELF_DB_BASE_NS 93750
`define ELF_CLK_NS 100
`define ELF_DB_BASE_CYC ((`ELF_DB_BASE_NS + `ELF_CLK_NS - 1) / `ELF_CLK_NS)
// code 1 is 1.5 ms; later codes double it
`define ELF_DB_STEP_NS 1500000
`define ELF_DB_STEP_CYC (`ELF_DB_STEP_NS / `ELF_CLK_NS)

`endif

// ---- design/elf_debounce.v ----
/*
 * Debounce of one event channel: the output follows the synchronised input
 * only after it has stayed stable for the selected period.
 * Assumes the input is already synchronised to clk.
 */
`default_nettype none

module elf_debounce #(
    parameter CW = 24
) (
    input wire clk,              // logger clock
    input wire rst,              // async reset, active high
    input wire clear,            // logger clear pulse
    input wire bypass,           // debounce disabled for this channel
    input wire [CW-1:0] period,  // stable cycles needed
    input wire din,              // synchronised input level
    output reg dout              // debounced level
);
    reg [CW-1:0] cnt;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= {CW{1'b0}};
            dout <= 1'b0;
        end else if (clear || bypass || din == dout) begin
            cnt <= {CW{1'b0}};
            if (bypass)
                dout <= din;
        end else if (cnt >= period) begin
            cnt <= {CW{1'b0}};
            dout <= din;
        end else begin
            cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
        end
    end
endmodule

`default_nettype wire

// ---- design/elf_logger.v ----
/*
 * Event logger control: control registers, debounce, channel priority,
 * 16-entry cyclic event store, pointers and status flags.
 * Assumes a simple synchronous register port on clk and channel event
 * levels arriving from outside the clock domain.
 */
// Behaviour
// R1: status flags leave the block so fifo full can raise an interrupt.
// R2: debounce code 0 is 93.75 us, code 1 1.5 ms, doubling to 768 ms.
// R3: clock request bit keeps system clock on while entries remain unread.
// R4: writing 1 to clear bit empties store, zeroes pointers and status.
// R5: stamp timer bit picks timer one or two; change only while disabled.
// R6: threshold flag set while free locations are at or below threshold.
// R7: full flag set when all entries unread; cleared by new read index.
// R8: pending flag set while at least one entry is unread.
// R9: write index is read-only and names the next storage location.
// R10: software advances read index after reading entries.
// R11: one event logged per cycle, lowest channel first, others stay queued.
// R12: store fills cyclically and never overwrites unread entries.
// R13: entries hold source, polarity and 32-bit stamp of chosen timer.
// R14: repeat filter drops events matching an unread entry.
// R15: clear bit reads zero, acts as one-cycle pulse.
// R16: reserved debounce codes are stored and act as the longest period.
`default_nettype none
`include "elf_regs.vh"

module elf_logger #(
    parameter NCH = 16,
    parameter SRCW = 10,
    parameter DEPTH = 16,
    parameter AW = 4,
    parameter CW = 24
) (
    input wire clk,                       // logger clock, 10 MHz
    input wire rst,                       // async reset, active high
    input wire reg_wr,                    // register write strobe
    input wire reg_rd,                    // register read strobe
    input wire [`ELF_ADDR_W-1:0] reg_addr,// register byte address
    input wire [31:0] reg_wdata,          // register write data
    output reg [31:0] reg_rdata,          // read data, valid cycle after reg_rd
    input wire [NCH-1:0] ch_in,           // channel source levels, async
    input wire [NCH-1:0] ch_enable,       // channel enables
    input wire [NCH-1:0] ch_polarity,     // 1 = falling edge
    input wire [NCH-1:0] ch_debounce,     // debounce enables
    input wire [NCH-1:0] channel_repeat_filter, // per-channel repeat filter
    input wire [NCH*SRCW-1:0] ch_source,  // source identifiers
    input wire [31:0] timer1_count,       // first timer count
    input wire [31:0] timer2_count,       // second timer count
    input wire [AW-1:0] entry_sel,        // entry chosen for reading
    output reg [SRCW-1:0] entry_id,       // selected entry source
    output reg entry_pol,                 // selected entry polarity
    output reg [31:0] entry_stamp,        // selected entry stamp
    output reg fifo_full_flag,            // store full
    output reg threshold_reached_flag,    // free space at threshold
    output reg fifo_pending_flag,         // unread entries exist
    output reg system_clock_request       // keep system clock enabled
);
    reg logger_enable, logger_clear, clock_request_when_pending, stamp_timer_choice;
    reg [3:0] debounce_period_sel;
    reg [3:0] free_space_threshold;
    reg [AW-1:0] write_index, read_index;
    reg full;
    reg [NCH-1:0] s1, s2, prev, queued;
    reg [SRCW-1:0] mem_id [0:DEPTH-1];
    reg mem_pol [0:DEPTH-1];
    reg [31:0] mem_stamp [0:DEPTH-1];
    wire [NCH-1:0] deb;
    reg [CW-1:0] period;
    reg [AW-1:0] used_lo;
    reg [AW:0] used, free_cnt;
    reg [NCH-1:0] edge_hit, dup;
    reg [AW-1:0] k;
    reg pick_valid;
    reg [AW-1:0] pick;
    integer i, j;

    wire sel_ctl = reg_addr == `ELF_OFF_CONTROL;
    wire sel_tmr = reg_addr == `ELF_OFF_TIMER_SRC;
    wire sel_thr = reg_addr == `ELF_OFF_THRESHOLD;
    wire sel_ps = reg_addr == `ELF_OFF_PTR_STATUS;

    // sized copies so the period and occupancy maths never drop bits silently
    localparam [CW-1:0] DB_BASE = `ELF_DB_BASE_CYC;
    localparam [CW-1:0] DB_STEP = `ELF_DB_STEP_CYC;
    localparam [AW:0] DEPTH_W = DEPTH;

    // reserved codes saturate at the longest period [R16]
    always @* begin
        if (debounce_period_sel == 4'h0)
            period = DB_BASE; // [R2]
        else if (debounce_period_sel > `ELF_DB_MAX_CODE)
            period = DB_STEP << 9;
        else
            period = DB_STEP << (debounce_period_sel - 4'h1); // [R2]
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : gch
            elf_debounce #(.CW(CW)) u_db (
                .clk(clk),
                .rst(rst),
                .clear(logger_clear),
                .bypass(~ch_debounce[g]),
                .period(period),
                .din(s2[g]),
                .dout(deb[g])
            );
        end
    endgenerate

    // occupancy: pointers equal means empty or full, resolved by the flag
    always @* begin
        k = {AW{1'b0}};
        used_lo = write_index - read_index;
        used = full ? DEPTH_W : {1'b0, used_lo};
        free_cnt = DEPTH_W - used;
        dup = {NCH{1'b0}};
        for (i = 0; i < NCH; i = i + 1) begin
            for (j = 0; j < DEPTH; j = j + 1) begin
                k = j[AW-1:0];
                if ((k - read_index) < used_lo || full)
                    if (mem_id[j] == ch_source[i*SRCW +: SRCW] && mem_pol[j] == ch_polarity[i])
                        dup[i] = channel_repeat_filter[i]; // [R14]
            end
        end
        // initial state counts as an edge when the logger is enabled
        edge_hit = ch_enable & ((~ch_polarity & deb & ~prev) | (ch_polarity & ~deb & prev));
        pick_valid = 1'b0;
        pick = {AW{1'b0}};
        for (i = NCH - 1; i >= 0; i = i - 1) begin
            if (queued[i] && !dup[i]) begin
                pick_valid = 1'b1;
                pick = i[AW-1:0]; // [R11]
            end
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s1 <= {NCH{1'b0}};
            s2 <= {NCH{1'b0}};
        end else begin
            s1 <= ch_in;
            s2 <= s1;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            logger_enable <= 1'b0;
            logger_clear <= 1'b0;
            clock_request_when_pending <= 1'b0;
            debounce_period_sel <= 4'h0;
            stamp_timer_choice <= 1'b0;
            free_space_threshold <= `ELF_RST_THRESHOLD;
            read_index <= {AW{1'b0}};
            write_index <= {AW{1'b0}};
            full <= 1'b0;
            prev <= {NCH{1'b0}};
            queued <= {NCH{1'b0}};
            reg_rdata <= 32'h00000000;
        end else begin
            logger_clear <= 1'b0; // [R15]
            if (reg_wr && sel_ctl) begin
                logger_enable <= reg_wdata[`ELF_CTL_EN_BIT];
                logger_clear <= reg_wdata[`ELF_CTL_CLR_BIT]; // [R4]
                clock_request_when_pending <= reg_wdata[`ELF_CTL_CLKREQ_BIT];
                debounce_period_sel <= reg_wdata[`ELF_CTL_DB_MSB:`ELF_CTL_DB_LSB]; // [R16]
            end
            // software keeps this steady while enabled; hardware does not lock it
            if (reg_wr && sel_tmr)
                stamp_timer_choice <= reg_wdata[0]; // [R5]
            if (reg_wr && sel_thr)
                free_space_threshold <= reg_wdata[3:0];
            if (logger_clear) begin
                read_index <= {AW{1'b0}}; // [R4]
                write_index <= {AW{1'b0}};
                full <= 1'b0;
                queued <= {NCH{1'b0}};
                prev <= {NCH{1'b0}};
            end else begin
                if (reg_wr && sel_ps) begin
                    read_index <= reg_wdata[`ELF_PS_RIDX_MSB:`ELF_PS_RIDX_LSB]; // [R10]
                    if (reg_wdata[`ELF_PS_RIDX_MSB:`ELF_PS_RIDX_LSB] != read_index)
                        full <= 1'b0; // [R7]
                end
                if (logger_enable) begin
                    prev <= deb;
                    // edges seen while full are dropped, not held for later [R12]
                    queued <= (queued | (full ? {NCH{1'b0}} : edge_hit)) & ~(dup & queued);
                    if (pick_valid && !full) begin
                        queued[pick] <= 1'b0; // [R11]
                        write_index <= write_index + {{(AW-1){1'b0}}, 1'b1}; // [R9]
                        if (write_index + {{(AW-1){1'b0}}, 1'b1} == read_index
                                && !(reg_wr && sel_ps))
                            full <= 1'b1; // [R7]
                    end
                end else begin
                    // disabled: next enable sees the initial level as an edge
                    prev <= ch_polarity;
                    queued <= {NCH{1'b0}};
                end
            end
            reg_rdata <= 32'h00000000;
            if (reg_rd) begin
                if (sel_ctl)
                    reg_rdata <= {12'h000, debounce_period_sel, 7'h00,
                        clock_request_when_pending, 6'h00, 1'b0, logger_enable}; // [R15]
                else if (sel_tmr)
                    reg_rdata <= {31'h00000000, stamp_timer_choice};
                else if (sel_thr)
                    reg_rdata <= {28'h0000000, free_space_threshold};
                else if (sel_ps)
                    reg_rdata <= {13'h0000, fifo_full_flag, threshold_reached_flag,
                        fifo_pending_flag, 4'h0, write_index, 4'h0, read_index}; // [R9]
            end
        end
    end

    // store never written while full, so unread entries survive [R12]
    always @(posedge clk) begin
        if (logger_enable && !logger_clear && pick_valid && !full) begin
            mem_id[write_index] <= ch_source[pick*SRCW +: SRCW]; // [R13]
            mem_pol[write_index] <= ch_polarity[pick];
            mem_stamp[write_index] <= stamp_timer_choice ? timer2_count : timer1_count; // [R5]
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            fifo_full_flag <= 1'b0;
            threshold_reached_flag <= 1'b0;
            fifo_pending_flag <= 1'b0;
            system_clock_request <= 1'b0;
            entry_id <= {SRCW{1'b0}};
            entry_pol <= 1'b0;
            entry_stamp <= 32'h00000000;
        end else begin
            fifo_full_flag <= full && !logger_clear; // [R1]
            threshold_reached_flag <= !logger_clear
                && free_cnt <= {1'b0, free_space_threshold}; // [R6]
            fifo_pending_flag <= !logger_clear && used != {(AW+1){1'b0}}; // [R8]
            system_clock_request <= clock_request_when_pending && !logger_clear
                && used != {(AW+1){1'b0}}; // [R3]
            entry_id <= mem_id[entry_sel];
            entry_pol <= mem_pol[entry_sel];
            entry_stamp <= mem_stamp[entry_sel];
        end
    end
endmodule

`default_nettype wire

// ---- tb/elf_logger_asserts.sv ----
/* Checker for elf_logger: flag relations, clear and read-port timing.
   Assumes it is bound to elf_logger and sees only its ports. */
`default_nettype none
`include "elf_regs.vh"
module elf_logger_asserts (
    input wire logic clk, // logger clock
    input wire logic rst, // async reset
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [`ELF_ADDR_W-1:0] reg_addr, // address
    input wire logic [31:0] reg_wdata, // write data
    input wire logic [31:0] reg_rdata, // read data
    input wire logic fifo_full_flag, // full
    input wire logic threshold_reached_flag, // threshold
    input wire logic fifo_pending_flag, // pending
    input wire logic system_clock_request // clock request
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire ctl = reg_addr == `ELF_OFF_CONTROL;
    property p_full_pend; fifo_full_flag |-> fifo_pending_flag; endproperty
    a_full_pend: assert property (p_full_pend) else $error("full without pending");
    property p_full_thr; fifo_full_flag |-> threshold_reached_flag; endproperty
    a_full_thr: assert property (p_full_thr) else $error("full without threshold");
    property p_empty_thr; !fifo_pending_flag |-> !threshold_reached_flag; endproperty
    a_empty_thr: assert property (p_empty_thr) else $error("threshold while empty");
    property p_clkreq; system_clock_request |-> fifo_pending_flag; endproperty
    a_clkreq: assert property (p_clkreq) else $error("clock request while empty");
    property p_clear;
        reg_wr && ctl && reg_wdata[1] |-> ##[3:5] !fifo_full_flag && !fifo_pending_flag;
    endproperty
    a_clear: assert property (p_clear) else $error("clear left flags set");
    // full may only drop after a register write one or two edges earlier
    property p_full_hold; !reg_wr ##1 (fifo_full_flag && !reg_wr) |=> fifo_full_flag; endproperty
    a_full_hold: assert property (p_full_hold) else $error("full dropped alone");
    property p_pend_hold;
        !reg_wr ##1 (fifo_pending_flag && !reg_wr) |=> fifo_pending_flag;
    endproperty
    a_pend_hold: assert property (p_pend_hold) else $error("pending dropped alone");
    property p_clr_zero; $past(reg_rd) && $past(ctl) |-> !reg_rdata[1]; endproperty
    a_clr_zero: assert property (p_clr_zero) else $error("clear bit read as one");
endmodule
bind elf_logger elf_logger_asserts u_chk (.clk(clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .fifo_full_flag(fifo_full_flag), .threshold_reached_flag(threshold_reached_flag),
    .fifo_pending_flag(fifo_pending_flag), .system_clock_request(system_clock_request));
`default_nettype wire

// ---- tb/elf_logger_tb.sv ----
/* Self-checking bench for elf_logger: registers, logging, flags, clear.
   Assumes the checker is bound from its own file; debounce runs on one channel only. */
`default_nettype none
`include "elf_regs.vh"
module elf_logger_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
    logic [23:0] reg_addr = 24'h0;
    logic [31:0] reg_wdata = 32'h0, t1 = 32'h0, t2 = 32'h0, rv;
    logic [15:0] ch_in = 16'h0, ch_en = 16'h0009, seed = 16'h0012, db = 16'h0, filt = 16'h0;
    logic [159:0] src = 160'h0;
    logic [3:0] sel = 4'h0;
    wire [31:0] rdata, e_stamp;
    wire [9:0] e_id;
    wire e_pol, full, thr, pend, creq;
    int miscompares = 0, n_checks = 0, cnt = 0, wp = 0, rp = 0, th = 1, ts = 0, i;
    logic [31:0] m_stamp [16];
    logic [9:0] m_id [16];
    logic [23:0] ad [4] = '{`ELF_OFF_CONTROL, `ELF_OFF_TIMER_SRC, `ELF_OFF_THRESHOLD, 24'h110004};
    logic [31:0] rs [4] = '{32'h0, 32'h0, 32'h1, 32'h0};
    elf_logger DUT (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(rdata), .ch_in(ch_in), .ch_enable(ch_en),
        .ch_polarity(16'h0), .ch_debounce(db), .channel_repeat_filter(filt),
        .ch_source(src), .timer1_count(t1), .timer2_count(t2), .entry_sel(sel),
        .entry_id(e_id), .entry_pol(e_pol), .entry_stamp(e_stamp), .fifo_full_flag(full),
        .threshold_reached_flag(thr), .fifo_pending_flag(pend), .system_clock_request(creq));
    always #50 clk = ~clk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // strobes drop a full cycle before the next access so no signal moves twice per step
    task automatic wr(input logic [23:0] a, input logic [31:0] d);
        reg_wr = 1'h1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'h0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [23:0] a);
        reg_rd = 1'h1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'h0;
        rv = rdata;
        @(negedge clk);
    endtask
    task automatic status();
        logic f, p, w;
        f = cnt == 16;
        p = cnt != 0;
        w = 16 - cnt <= th;
        rd(`ELF_OFF_PTR_STATUS);
        chk(rv, {13'h0, f, w, p, 4'h0, 4'(wp), 4'h0, 4'(rp)});
        chk(32'({full, thr, pend, creq}), 32'({f, w, p, p}));
    endtask
    task automatic pulse(input logic [15:0] m, input int hold = 8);
        ch_in = m;
        repeat (hold) @(negedge clk);
        for (i = 0; i < 16; i++)
            if (m[i] && ch_en[i] && cnt < 16) begin
                m_id[wp] = src[i*10+:10];
                m_stamp[wp] = ts ? t2 : t1;
                wp = (wp + 1) % 16;
                cnt++;
            end
        ch_in = 16'h0;
        repeat (6) @(negedge clk);
    endtask
    task automatic ent(input int n);
        int k;
        for (int j = n; j > 0; j--) begin
            k = (wp - j) & 15;
            sel = 4'(k);
            @(negedge clk);
            chk({21'h0, e_pol, e_id}, {22'h0, m_id[k]});
            chk(e_stamp, m_stamp[k]);
        end
    endtask
    initial begin
        #2000000;
        miscompares++;
        print_verdict();
    end
    initial begin
        for (i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            src[i*10+:10] = seed[9:0];
        end
        repeat (20) @(negedge clk);
        rst = 1'h0;
        for (int a = 0; a < 4; a++) begin
            rd(ad[a]);
            chk(rv, rs[a]);
        end
        ts = seed[4];
        th = seed[3:0];
        wr(`ELF_OFF_TIMER_SRC, 32'(ts));
        wr(`ELF_OFF_THRESHOLD, 32'(th));
        rd(`ELF_OFF_THRESHOLD);
        chk(rv, 32'(th));
        // every debounce code, with clear set; logger ends enabled with clock request
        for (int c = 0; c < 16; c++) begin
            wr(`ELF_OFF_CONTROL, {12'h0, 4'(c), 7'h0, 1'h1, 8'h03});
            rd(`ELF_OFF_CONTROL);
            chk(rv, {12'h0, 4'(c), 7'h0, 1'h1, 8'h01});
        end
        status();
        for (int k = 0; k < 17; k++) begin
            seed = lfsr(seed);
            t1 = {seed, ~seed};
            t2 = {~seed, seed};
            pulse(16'h0001);
            status();
        end
        ent(16);
        wr(`ELF_OFF_PTR_STATUS, 32'h0);
        status();
        rp = 5;
        cnt = 11;
        wr(`ELF_OFF_PTR_STATUS, 32'h5);
        status();
        pulse(16'h0009);
        status();
        ent(2);
        wr(`ELF_OFF_CONTROL, 32'h0000_0103);
        {cnt, wp, rp} = '0;
        repeat (4) @(negedge clk);
        status();
        pulse(16'h0008);
        status();
        ent(1);
        // filter and debounce are changed only while their channels are off
        ch_en = 16'h0000;
        @(negedge clk);
        filt = 16'h0008;
        db = 16'h0001;
        @(negedge clk);
        ch_en = 16'h0009;
        // channel 3 repeats the unread entry: must be dropped
        ch_in = 16'h0008;
        repeat (8) @(negedge clk);
        ch_in = 16'h0000;
        repeat (6) @(negedge clk);
        status();
        // high for less than the base period: must be swallowed
        ch_in = 16'h0001;
        repeat (900) @(negedge clk);
        ch_in = 16'h0000;
        repeat (6) @(negedge clk);
        status();
        pulse(16'h0001, 960);
        status();
        ent(1);
        print_verdict();
    end
endmodule
`default_nettype wire
